// ===== hw/pbdc_axil.sv
`timescale 1ns/1ps
module pbdc_axil import pbdc_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [REG_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [REG_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic reg_wr,
  output logic [REG_AW-1:0] reg_waddr,
  output logic [31:0] reg_wdata,
  output logic [3:0] reg_wstrb,
  input wire logic reg_wok,
  output logic reg_rd,
  output logic [REG_AW-1:0] reg_raddr,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rok
);
  typedef struct packed {
    logic aw;
    logic [REG_AW-1:0] awa;
    logic w;
    logic [31:0] wd;
    logic [3:0] ws;
    logic wr;
    logic bv;
    logic [1:0] br;
    logic ar;
    logic [REG_AW-1:0] ara;
    logic rd;
    logic rv;
  } pbdc_axil_t;

  pbdc_axil_t q;
  pbdc_axil_t d;

  assign s_axi_awready = !q.aw && !q.wr && !q.bv;
  assign s_axi_wready = !q.w && !q.wr && !q.bv;
  assign s_axi_arready = !q.ar;

  always_comb begin
    d = q;
    d.wr = 1'b0;
    d.rd = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw = 1'b1;
      d.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w = 1'b1;
      d.wd = s_axi_wdata;
      d.ws = s_axi_wstrb;
    end
    if (q.aw && q.w) begin
      d.wr = 1'b1;
      d.aw = 1'b0;
      d.w = 1'b0;
    end
    if (q.wr) begin
      d.bv = 1'b1;
      d.br = reg_wok ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.bv && s_axi_bready) begin
      d.bv = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      d.ar = 1'b1;
      d.ara = s_axi_araddr;
      d.rd = 1'b1;
    end
    // Read data is registered by the owner during the pulse
    if (q.rd) begin
      d.rv = 1'b1;
    end
    if (q.rv && s_axi_rready) begin
      d.rv = 1'b0;
      d.ar = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign s_axi_bvalid = q.bv;
  assign s_axi_bresp = q.br;
  assign s_axi_rvalid = q.rv;
  assign s_axi_rdata = reg_rdata;
  assign s_axi_rresp = reg_rok ? RESP_OKAY : RESP_SLVERR;
  assign reg_wr = q.wr;
  assign reg_waddr = q.awa;
  assign reg_wdata = q.wd;
  assign reg_wstrb = q.ws;
  assign reg_rd = q.rd;
  assign reg_raddr = q.ara;
endmodule : pbdc_axil

// ===== hw/pbdc_recstore.sv
`timescale 1ns/1ps
module pbdc_recstore import pbdc_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic ins_en,
  input wire pbdc_rec_t ins_rec,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire pbdc_rec_t wr_rec,
  input wire logic rd_en,
  input wire logic [2:0] rd_idx,
  output pbdc_rec_t rd_rec,
  output pbdc_recs_t recs
);
  typedef struct packed {
    pbdc_recs_t recs;
    pbdc_rec_t rd;
  } pbdc_store_t;

  pbdc_store_t q;
  pbdc_store_t d;
  logic [REC_COUNT-1:0] ge;
  pbdc_recs_t shifted;

  ////////////////////////////////////////////////////////////////////////////
  // Entries stay sorted, so ge is a prefix and the new one lands after it
  for (genvar i = 0; i < REC_COUNT; i++) begin : g_ent
    assign ge[i] = (|q.recs[i]) && (q.recs[i].level >= ins_rec.level);
    if (i == 0) begin : g_first
      assign shifted[i] = ge[i] ? q.recs[i] : ins_rec;
    end else begin : g_rest
      assign shifted[i] = ge[i] ? q.recs[i] : (ge[i-1] ? ins_rec : q.recs[i-1]);
    end
  end

  // Weakest entry falls off the end when all eight are taken
  always_comb begin
    d = q;
    if (clear) begin
      d.recs = '0;
    end else if (wr_en) begin
      d.recs[wr_idx] = wr_rec;
    end else if (ins_en) begin
      d.recs = shifted;
    end
    if (rd_en) begin
      d.rd = q.recs[rd_idx];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rd_rec = q.rd;
  assign recs = q.recs;
endmodule : pbdc_recstore

// ===== hw/pbdc_top.sv
`timescale 1ns/1ps
module pbdc_top import pbdc_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [REG_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [REG_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pix_in_valid,
  input wire pbdc_pix_t pix_in,
  output logic pix_out_valid,
  output pbdc_pix_t pix_out
);
  typedef struct packed {
    logic [5:0] ctrl;
    logic [7:0] mode;
    logic [31:0] win;
    logic [7:0] win_hi;
    logic [23:0] lvl;
    logic [17:0] aux;
    pbdc_st_t st;
    logic done;
    logic [9:0] h;
    logic [9:0] v;
    logic max_ok;
    logic [9:0] max_lvl;
    logic [9:0] max_h;
    logic [9:0] max_v;
    logic [7:0] fcnt;
    logic a0_ok;
    logic [19:0] a0;
    logic a1_ok;
    logic [19:0] a1;
    pbdc_tap_t [4:0] tap;
    logic ov;
    pbdc_pix_t out;
    logic [31:0] rdata;
    logic rok;
    logic rrec;
  } pbdc_top_t;

  pbdc_top_t q;
  pbdc_top_t d;

  logic reg_wr;
  logic [REG_AW-1:0] reg_waddr;
  logic [31:0] reg_wdata;
  logic [3:0] reg_wstrb;
  logic reg_wok;
  logic reg_rd;
  logic [REG_AW-1:0] reg_raddr;
  logic [31:0] reg_rdata;
  pbdc_recs_t recs;
  pbdc_rec_t rec_rd;
  pbdc_rec_t rec_wr;
  logic [31:0] rec_mw;
  logic rec_wen;
  logic ins_en;
  pbdc_rec_t ins_rec;
  logic clear_eff;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave and record store
  pbdc_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .reg_wr(reg_wr),
    .reg_waddr(reg_waddr),
    .reg_wdata(reg_wdata),
    .reg_wstrb(reg_wstrb),
    .reg_wok(reg_wok),
    .reg_rd(reg_rd),
    .reg_raddr(reg_raddr),
    .reg_rdata(reg_rdata),
    .reg_rok(q.rok)
  );

  pbdc_recstore u_store (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(clear_eff),
    .ins_en(ins_en),
    .ins_rec(ins_rec),
    .wr_en(rec_wen),
    .wr_idx(reg_waddr[4:2]),
    .wr_rec(rec_wr),
    .rd_en(reg_rd),
    .rd_idx(reg_raddr[4:2]),
    .rd_rec(rec_rd),
    .recs(recs)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction : merge

  function automatic logic is_rec(input logic [REG_AW-1:0] a);
    is_rec = (a[7:5] == OFS_REC[7:5]) && (a[1:0] == 2'h0);
  endfunction : is_rec

  function automatic logic any_hit(input pbdc_recs_t r, input logic [9:0] v,
                                   input logic [9:0] h);
    any_hit = 1'b0;
    for (int i = 0; i < REC_COUNT; i++) begin
      if ((|r[i]) && r[i].row == v && r[i].col == h) begin
        any_hit = 1'b1;
      end
    end
  endfunction : any_hit

  ////////////////////////////////////////////////////////////////////////////
  // Decoded settings
  logic [9:0] hs;
  logic [9:0] vs;
  logic [9:0] hw;
  logic [9:0] vw;
  logic [10:0] hend;
  logic [10:0] vend;
  logic [9:0] thr;
  logic [9:0] dark;
  logic [9:0] tst;
  logic [7:0] wait_n;

  assign hs = {q.win_hi[WHI_HS_LSB +: 2], q.win[WIN_HS_LSB +: 8]};
  assign vs = {q.win_hi[WHI_VS_LSB +: 2], q.win[WIN_VS_LSB +: 8]};
  assign hw = {q.win_hi[WHI_HW_LSB +: 2], q.win[WIN_HW_LSB +: 8]};
  assign vw = {q.win_hi[WHI_VW_LSB +: 2], q.win[WIN_VW_LSB +: 8]};
  assign hend = {1'b0, hs} + {1'b0, hw};
  assign vend = {1'b0, vs} + {1'b0, vw};
  assign thr = {q.lvl[LV_THR_HI_LSB +: 2], q.lvl[LV_THR_LSB +: 8]};
  assign dark = {q.lvl[LV_DARK_HI_LSB +: 2], q.lvl[LV_DARK_LSB +: 8]};
  assign tst = {q.aux[AX_TST_HI_LSB +: 2], q.aux[AX_TST_LSB +: 8]};
  assign wait_n = q.aux[AX_WAIT_LSB +: 8];

  function automatic logic in_win(input logic [9:0] h, input logic [9:0] v);
    in_win = h >= hs && {1'b0, h} < hend && v >= vs && {1'b0, v} < vend;
  endfunction : in_win

  function automatic logic on_edge(input logic [9:0] h, input logic [9:0] v);
    on_edge = in_win(h, v) && (h == hs || {1'b0, h} + 11'h001 == hend ||
                               v == vs || {1'b0, v} + 11'h001 == vend);
  endfunction : on_edge

  ////////////////////////////////////////////////////////////////////////////
  // Pixel position, test injection and candidates
  logic [9:0] cur_h;
  logic [9:0] cur_v;
  logic inj;
  logic [9:0] px;
  logic [9:0] dlev;
  logic live;
  logic det_ok;
  logic win_cur;
  logic scan_on;
  logic st_ins;
  logic dyn_cand;
  logic fend;
  logic sample;
  logic dyn_ins;
  pbdc_tap_t c;
  logic hit_c;
  logic [10:0] nsum;

  assign cur_h = (pix_in.sof || pix_in.sol) ? 10'h000 : q.h + 10'h001;
  assign cur_v = pix_in.sof ? 10'h000 : (pix_in.sol ? q.v + 10'h001 : q.v);
  // Test pixel sits in the window centre so that it is always seen
  assign inj = q.ctrl[CB_TEST] && cur_h == hs + (hw >> 1) && cur_v == vs + (vw >> 1);
  assign px = inj ? tst : pix_in.data;
  assign live = q.ctrl[CB_LIVE];
  assign det_ok = !q.ctrl[CB_CLEAR];
  assign clear_eff = q.ctrl[CB_CLEAR] && !live;
  assign win_cur = in_win(cur_h, cur_v);
  assign dlev = (px > dark) ? px - dark : 10'h000;
  assign scan_on = (q.st == ST_SCAN && !pix_in.sof) || (q.st == ST_ARM && pix_in.sof);
  assign st_ins = pix_in_valid && scan_on && det_ok && win_cur && px > thr &&
                  !any_hit(recs, cur_v, cur_h);
  assign dyn_cand = pix_in_valid && live && det_ok && win_cur && dlev > thr;
  assign fend = pix_in_valid && pix_in.sof && live && det_ok;
  assign sample = ({1'b0, q.fcnt} + 9'h001) >= {1'b0, wait_n};
  assign dyn_ins = fend && sample && q.a0_ok && q.a1_ok && q.max_ok &&
                   q.a0 == q.a1 && q.a1 == {q.max_v, q.max_h} &&
                   !any_hit(recs, q.max_v, q.max_h);
  assign ins_en = st_ins || dyn_ins;
  // Static wins a same-cycle collision; the live candidate recurs later
  assign ins_rec = st_ins ? pbdc_rec_t'{dyn: 1'b0, row: cur_v, col: cur_h, level: px}
                          : pbdc_rec_t'{dyn: 1'b1, row: q.max_v, col: q.max_h, level: q.max_lvl};

  assign c = q.tap[2];
  assign hit_c = any_hit(recs, c.v, c.h);
  assign nsum = {1'b0, q.tap[0].p.data} + {1'b0, q.tap[4].p.data};

  assign rec_wen = reg_wr && is_rec(reg_waddr);
  assign rec_mw = merge({1'b0, recs[reg_waddr[4:2]]}, reg_wdata, reg_wstrb);
  assign rec_wr = pbdc_rec_t'(rec_mw[30:0]);
  assign reg_wok = is_rec(reg_waddr) || reg_waddr == OFS_CTRL || reg_waddr == OFS_MODE ||
                   reg_waddr == OFS_STATUS || reg_waddr == OFS_WIN ||
                   reg_waddr == OFS_WIN_HI || reg_waddr == OFS_LEVEL || reg_waddr == OFS_AUX;
  assign reg_rdata = q.rrec ? {1'b0, rec_rd} : q.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d = q;
    // Static run: arm, scan one full field, then finish
    case (q.st)
      ST_ARM: begin
        if (pix_in_valid && pix_in.sof) begin
          d.st = ST_SCAN;
        end
      end
      ST_SCAN: begin
        if (pix_in_valid && pix_in.sof) begin
          d.st = ST_DONE;
          d.done = 1'b1;
        end
      end
      ST_IDLE, ST_DONE: begin
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase

    // Live search: field maximum and anchors N fields apart
    if (pix_in_valid && pix_in.sof) begin
      d.max_ok = 1'b0;
    end
    if (fend) begin
      if (sample) begin
        d.fcnt = 8'h00;
        d.a0 = q.a1;
        d.a0_ok = q.a1_ok;
        d.a1 = {q.max_v, q.max_h};
        d.a1_ok = q.max_ok;
      end else begin
        d.fcnt = q.fcnt + 8'h01;
      end
    end
    if (dyn_cand && (!d.max_ok || dlev > d.max_lvl)) begin
      d.max_ok = 1'b1;
      d.max_lvl = dlev;
      d.max_h = cur_h;
      d.max_v = cur_v;
    end
    if (!live) begin
      d.a0_ok = 1'b0;
      d.a1_ok = 1'b0;
      d.fcnt = 8'h00;
    end

    // Pixel path: five-tap line, centre is corrected or overlaid
    d.ov = pix_in_valid && q.tap[2].vld;
    if (pix_in_valid) begin
      d.h = cur_h;
      d.v = cur_v;
      d.tap[4:1] = q.tap[3:0];
      d.tap[0] = '{vld: 1'b1, p: '{sof: pix_in.sof, sol: pix_in.sol, data: px}, h: cur_h,
                   v: cur_v};
      d.out = c.p;
      // Markers beat correction so a fixed pixel stays visible
      if (q.ctrl[CB_BOX] && on_edge(c.h, c.v)) begin
        d.out.data = PIX_MARK;
      end else if (q.ctrl[CB_MARK] && hit_c) begin
        d.out.data = PIX_MARK;
      end else if (q.ctrl[CB_CORRECT] && hit_c) begin
        // Neighbours two apart share the colour; line edges are not guarded
        d.out.data = nsum[10:1];
      end
    end

    // Register writes
    if (reg_wr) begin
      case (reg_waddr)
        OFS_CTRL: d.ctrl = 6'(merge(32'(q.ctrl), reg_wdata, reg_wstrb));
        OFS_MODE: begin
          d.mode = 8'(merge(32'(q.mode), reg_wdata, reg_wstrb));
          if (d.mode == MODE_STATIC && q.st == ST_IDLE) begin
            d.st = ST_ARM;
            d.done = 1'b0;
          end else if (d.mode == MODE_NORMAL) begin
            d.st = ST_IDLE;
            d.done = (q.st == ST_SCAN) && pix_in_valid && pix_in.sof;
          end
        end
        OFS_WIN: d.win = merge(q.win, reg_wdata, reg_wstrb);
        OFS_WIN_HI: d.win_hi = 8'(merge(32'(q.win_hi), reg_wdata, reg_wstrb));
        OFS_LEVEL: d.lvl = 24'(merge(32'(q.lvl), reg_wdata, reg_wstrb));
        OFS_AUX: d.aux = 18'(merge(32'(q.aux), reg_wdata, reg_wstrb));
        default: begin
        end
      endcase
    end

    // Register reads, captured on the slave's pulse
    if (reg_rd) begin
      d.rrec = is_rec(reg_raddr);
      d.rok = 1'b1;
      case (reg_raddr)
        OFS_CTRL: d.rdata = 32'(q.ctrl);
        OFS_MODE: d.rdata = 32'(q.mode);
        OFS_STATUS: d.rdata = {30'h0, (q.st == ST_ARM || q.st == ST_SCAN), q.done};
        OFS_WIN: d.rdata = q.win;
        OFS_WIN_HI: d.rdata = 32'(q.win_hi);
        OFS_LEVEL: d.rdata = 32'(q.lvl);
        OFS_AUX: d.rdata = 32'(q.aux);
        default: begin
          d.rdata = 32'h0000_0000;
          d.rok = is_rec(reg_raddr);
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.st <= ST_IDLE;
      q.rok <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign pix_out_valid = q.ov;
  assign pix_out = q.out;
endmodule : pbdc_top

// ===== inc/pbdc_pkg.sv
package pbdc_pkg;
  // Register byte offsets on the bus
  localparam int REG_AW = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_WIN = 8'h0C;
  localparam logic [7:0] OFS_WIN_HI = 8'h10;
  localparam logic [7:0] OFS_LEVEL = 8'h14;
  localparam logic [7:0] OFS_AUX = 8'h18;
  localparam logic [7:0] OFS_REC = 8'h40;
  localparam int REC_COUNT = 8;
  // Control word bits
  localparam int CB_CORRECT = 0;
  localparam int CB_BOX = 1;
  localparam int CB_MARK = 2;
  localparam int CB_TEST = 3;
  localparam int CB_LIVE = 4;
  localparam int CB_CLEAR = 5;
  localparam logic [5:0] CTRL_RST = 6'h10;
  // Mode byte values
  localparam logic [7:0] MODE_NORMAL = 8'h00;
  localparam logic [7:0] MODE_STATIC = 8'h22;
  // Window word: four low bytes, then packed high bits
  localparam int WIN_HS_LSB = 0;
  localparam int WIN_VS_LSB = 8;
  localparam int WIN_HW_LSB = 16;
  localparam int WIN_VW_LSB = 24;
  localparam int WHI_HS_LSB = 0;
  localparam int WHI_VS_LSB = 2;
  localparam int WHI_HW_LSB = 4;
  localparam int WHI_VW_LSB = 6;
  // Level word: threshold low, shared high byte, dark low
  localparam int LV_THR_LSB = 0;
  localparam int LV_THR_HI_LSB = 8;
  localparam int LV_DARK_HI_LSB = 14;
  localparam int LV_DARK_LSB = 16;
  // Aux word: wait count, test level low, test level high
  localparam int AX_WAIT_LSB = 0;
  localparam int AX_TST_LSB = 8;
  localparam int AX_TST_HI_LSB = 16;
  localparam logic [9:0] PIX_MARK = 10'h3FF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ARM = 4'b0010,
    ST_SCAN = 4'b0100,
    ST_DONE = 4'b1000
  } pbdc_st_t;

  typedef struct packed {
    logic sof;
    logic sol;
    logic [9:0] data;
  } pbdc_pix_t;

  typedef struct packed {
    logic dyn;
    logic [9:0] row;
    logic [9:0] col;
    logic [9:0] level;
  } pbdc_rec_t;

  typedef pbdc_rec_t [REC_COUNT-1:0] pbdc_recs_t;

  typedef struct packed {
    logic vld;
    pbdc_pix_t p;
    logic [9:0] h;
    logic [9:0] v;
  } pbdc_tap_t;
endpackage : pbdc_pkg

// ===== tb/pbdc_sensor.sv
`timescale 1ns/1ps
module pbdc_sensor import pbdc_pkg::*; (
  input wire logic aclk,
  input wire logic run,
  input wire logic slow,
  output logic pix_in_valid,
  output pbdc_pix_t pix_in
);
  logic [2:0] h_q = '0;
  logic [2:0] v_q = '0;
  logic gap_q = '0;
  logic [9:0] lvl;
  // Frame of 8 x 6 with two hot pixels
  assign lvl = (h_q == 3'h5 && v_q == 3'h3) ? 10'h200 :
    (h_q == 3'h2 && v_q == 3'h1) ? 10'h180 : 10'h010;
  initial pix_in_valid = '0;
  initial pix_in = '0;
  always @(posedge aclk) begin
    gap_q <= slow && !gap_q;
    pix_in_valid <= run && !gap_q;
    if (run && !gap_q) begin
      pix_in <= '{sof: h_q == 3'h0 && v_q == 3'h0, sol: h_q == 3'h0, data: lvl};
      h_q <= h_q + 3'h1;
      if (h_q == 3'h7) v_q <= (v_q == 3'h5) ? 3'h0 : v_q + 3'h1;
    end else begin
      // Stale lines flip so a design must not trust them
      pix_in <= ~pix_in;
    end
  end
endmodule : pbdc_sensor

// ===== tb/pbdc_top_props.sv
`timescale 1ns/1ps
module pbdc_top_props import pbdc_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [REG_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pix_in_valid,
  input wire logic pix_out_valid,
  input wire pbdc_pix_t pix_out
);
  logic [REG_AW-1:0] ra_q;
  logic rec_r;
  logic bad_r;
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
  end
  assign rec_r = ra_q >= OFS_REC && ra_q < 8'h60;
  assign bad_r = (ra_q >= 8'h1C && ra_q < OFS_REC) || ra_q >= 8'h60;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid)
    else $error("read answer off time");
  rd_single_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken during answer");
  wr_single_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during answer");
  bad_addr_a: assert property (s_axi_rvalid && bad_r |-> s_axi_rresp == RESP_SLVERR)
    else $error("unmapped read not refused");
  rec_pad_a: assert property (s_axi_rvalid && rec_r |-> !s_axi_rdata[31])
    else $error("record top bit set");
  pix_gap_a: assert property (!pix_in_valid |=> !pix_out_valid)
    else $error("pixel out without pixel in");
  pix_hold_a: assert property (!pix_in_valid |=> $stable(pix_out))
    else $error("pixel out moved while idle");
endmodule : pbdc_top_props

bind pbdc_top pbdc_top_props i_pbdc_top_props (.*);

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top import pbdc_pkg::*; ();
  logic aclk = '0;
  logic aresetn = '0;
  logic [7:0] s_axi_awaddr = '0;
  logic [7:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = '0;
  logic s_axi_wvalid = '0;
  logic s_axi_bready = '0;
  logic s_axi_arvalid = '0;
  logic s_axi_rready = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic pix_in_valid, pix_out_valid;
  logic run = '0;
  logic slow = '0;
  pbdc_pix_t pix_in, pix_out;
  logic [9:0] obs [6][8];
  int fails = 0;
  int checked = 0;
  int h = 0;
  int v = 0;
  int fld = 0;
  always #5 aclk = ~aclk;
  pbdc_top i_pbdc_top (.*);
  pbdc_sensor i_pbdc_sensor (.*);
  always @(posedge aclk) begin
    if (pix_out_valid) begin
      h = pix_out.sol ? 0 : h + 1;
      v = pix_out.sof ? 0 : pix_out.sol ? v + 1 : v;
      fld = fld + int'(pix_out.sof);
      obs[v % 6][h % 8] = pix_out.data;
    end
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %0t saw %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic finish_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  task automatic lim(input int n);
    if (n >= 300) begin
      fails++;
      $display("MISMATCH %0t timeout", $time);
      finish_test();
    end
  endtask : lim
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = RESP_OKAY);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= '1;
    s_axi_wvalid <= '1;
    s_axi_bready <= '1;
    for (n = 0; n < 300; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= '0;
      if (s_axi_wready) s_axi_wvalid <= '0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= '0;
    lim(n);
    chk(32'(s_axi_bresp), 32'(e));
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= '1;
    s_axi_rready <= '1;
    for (n = 0; n < 300; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= '0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    s_axi_rready <= '0;
    lim(n);
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rchk
  task automatic fields(input int k);
    int n;
    int f;
    f = fld + k;
    for (n = 0; n < 3000 && fld < f; n++) @(posedge aclk);
    lim(n / 10);
  endtask : fields
  ////////////////////////////////////////
  initial begin
    logic [31:0] d;
    int n;
    logic [5:0] cv [6] = '{6'h01, 6'h00, 6'h05, 6'h02, 6'h00, 6'h08};
    int rw [6] = '{3, 3, 3, 0, 0, 3};
    int cl [6] = '{5, 5, 5, 1, 1, 4};
    logic [9:0] ex [6] = '{10'h010, 10'h200, 10'h3FF, 10'h3FF, 10'h010, 10'h2AB};
    repeat (5) @(posedge aclk);
    aresetn <= '1;
    rchk(OFS_CTRL, 32'h10);
    rchk(OFS_STATUS, 32'h0);
    wr(8'h20, 32'h1, RESP_SLVERR);
    rd(8'h20, d);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_WIN, 32'h0608_0000);
    wr(OFS_WIN_HI, 32'hFF);
    rchk(OFS_WIN_HI, 32'hFF);
    wr(OFS_WIN_HI, 32'h0);
    rchk(OFS_WIN, 32'h0608_0000);
    wr(OFS_LEVEL, 32'h0010_017F);
    wr(OFS_AUX, 32'h0002_AB02);
    run <= '1;
    wr(OFS_MODE, 32'h22);
    rd(OFS_STATUS, d);
    chk(32'(d[0]), 32'h0);
    for (n = 0; n < 300; n++) begin
      rd(OFS_STATUS, d);
      if (d[0]) break;
    end
    lim(n);
    chk(32'(d[0]), 32'h1);
    rchk(OFS_REC, {2'h0, 10'h3, 10'h5, 10'h200});
    rchk(OFS_REC + 8'h4, {2'h0, 10'h1, 10'h2, 10'h180});
    rchk(OFS_REC + 8'h8, 32'h0);
    wr(OFS_MODE, 32'h0);
    // Output overlays against the stored defect at row 3 col 5, the box edge and the test pixel
    for (int i = 0; i < 6; i++) begin
      wr(OFS_CTRL, {26'h0, cv[i]});
      fields(2);
      chk(32'(obs[rw[i]][cl[i]]), 32'(ex[i]));
    end
    // Zeroed slot stands for the saved erase of a static record
    wr(OFS_REC + 8'h4, 32'h0);
    rchk(OFS_REC + 8'h4, 32'h0);
    slow <= '1;
    // Clear held with live on: records kept, nothing detected
    wr(OFS_CTRL, 32'h31);
    fields(8);
    rchk(OFS_REC, {2'h0, 10'h3, 10'h5, 10'h200});
    wr(OFS_CTRL, 32'h20);
    rchk(OFS_REC, 32'h0);
    wr(OFS_CTRL, 32'h31);
    fields(8);
    rchk(OFS_REC, 32'h0);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_CTRL, 32'h11);
    for (n = 0; n < 300; n++) begin
      rd(OFS_REC, d);
      if (d !== 32'h0) break;
    end
    lim(n);
    chk(d, {2'h1, 10'h3, 10'h5, 10'h1F0});
    finish_test();
  end
endmodule : tb_top
